// >>> rtl/timer_cap_pkg.sv
// constants, register map and field layouts of the capture/compare timer
package timer_cap_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;
  typedef logic [CNT_W-1:0]  count_t;

  localparam addr_t OFF_CTRL0  = 8'h00;
  localparam addr_t OFF_OPTION = 8'h04;
  localparam addr_t OFF_EDGE   = 8'h08;
  localparam addr_t OFF_CCR0   = 8'h0C;
  localparam addr_t OFF_CCR1   = 8'h10;
  localparam addr_t OFF_BITCLR = 8'h14;
  localparam addr_t OFF_COUNT  = 8'h18;

  localparam logic [2:0] MODE_FREE = 3'h5;
  localparam logic [2:0] MODE_PWM  = 3'h6;

  localparam count_t CNT_MAX  = 16'hFFFF;
  localparam count_t CNT_ZERO = 16'h0000;
  localparam count_t CNT_ONE  = 16'h0001;

  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // option and bit-clear register bit positions
  localparam int OPT_FLAG_BIT = 0;
  localparam int OPT_CCS0_BIT = 4;
  localparam int OPT_CCS1_BIT = 5;
  localparam int BITCLR_BIT   = 0;

  // control register 0 layout: bit 4 ext clock, bit 3 run, bits 2:0 mode
  typedef struct packed {
    logic       ext_clk;
    logic       run;
    logic [2:0] mode;
  } ctrl_t;
  localparam int    CTRL_W     = 5;
  localparam ctrl_t CTRL_RESET = 5'h00;

  // edge select layout: chan1 in bits 3:2, chan0 in bits 1:0
  typedef struct packed {
    logic [1:0] chan1;
    logic [1:0] chan0;
  } edge_sel_t;
  localparam int        EDGE_W     = 4;
  localparam edge_sel_t EDGE_RESET = 4'h0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
  } apb_ctl_t;
endpackage

// >>> rtl/timer_capture_pulse_width.sv
// 16-bit timer channel pair: free-running and pulse width measurement modes
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - pulse width mode starts counting from zero when run bit is set
// - pulse width mode edge copies count, clears counter, raises channel irq
// - count at maximum wraps to zero on next count clock with wrap irq, unless a pulse width edge clears it in that cycle
// - wrap also sets sticky wrap flag, held until software clears
// - flag cleared by bit-clear or option write with bit 0 zero
// - bit-clear coinciding with a wrap leaves the flag set
// - external clock occupies input 0; channel 0 edge select must be none
// - free-running mode runs both channels independently
// - mode 101 is free-running; counter only wraps, cleared only when run is set
// - function select bit picks compare or capture per channel
// - compare match raises channel irq and toggles its output pin
// - compare register writes take effect at once, unbuffered
module timer_capture_pulse_width (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire timer_cap_pkg::apb_ctl_t apb_ctl,
  input  wire timer_cap_pkg::addr_t paddr,
  input  wire timer_cap_pkg::data_t pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output timer_cap_pkg::data_t      prdata,
  output logic                      pslverr,
  input  wire logic                 capture_input0_pin,
  input  wire logic                 capture_input1_pin,
  output logic [1:0]                timer_output_pin,
  output logic [1:0]                chan_match_capture_irq,
  output logic                      counter_wrap_irq
);
  import timer_cap_pkg::*;

  ctrl_t     timer_control_reg0;
  ctrl_t     next_timer_control_reg0;
  edge_sel_t edge_select_reg;
  edge_sel_t next_edge_select_reg;
  logic [1:0] chan_function_select;
  logic [1:0] next_chan_function_select;
  logic       wrap_flag;
  logic       next_wrap_flag;
  count_t     chan_capture_compare_reg [2];
  count_t     next_chan_capture_compare_reg [2];
  count_t     count;
  count_t     next_count;
  logic       run_q;
  logic [1:0] next_timer_output_pin;
  logic [1:0] next_irq;
  logic       next_wrap_irq;
  data_t      next_prdata;
  logic       next_pslverr;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync3;

  logic       wr_access;
  logic       setup;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] cap_edge;
  logic       mode_free;
  logic       mode_pwm;
  logic       running;
  logic       starting;
  logic       tick;
  logic       clear_hit;
  logic       wrap_evt;
  logic       bitclr_req;
  logic       optwr_clr;
  logic       ccr_wr [2];

  assign pready    = apb_ctl.psel & apb_ctl.penable;
  assign wr_access = pready & apb_ctl.pwrite;
  assign setup     = apb_ctl.psel & ~apb_ctl.penable;
  assign rise      = sync2 & ~sync3;
  assign fall      = ~sync2 & sync3;
  assign mode_free = (timer_control_reg0.mode == MODE_FREE);
  assign mode_pwm  = (timer_control_reg0.mode == MODE_PWM);
  assign running   = timer_control_reg0.run & run_q & (mode_free | mode_pwm);
  assign starting  = timer_control_reg0.run & ~run_q;
  // external clock counts on input 0 rising edges
  assign tick      = timer_control_reg0.ext_clk ? rise[0] : 1'b1;

  // channel 0 edges are blind while input 0 carries the count clock
  assign cap_edge[0] = ~timer_control_reg0.ext_clk &
    (((edge_select_reg.chan0 == EDGE_RISE) | (edge_select_reg.chan0 == EDGE_BOTH)) & rise[0] |
     ((edge_select_reg.chan0 == EDGE_FALL) | (edge_select_reg.chan0 == EDGE_BOTH)) & fall[0]);
  assign cap_edge[1] =
    (((edge_select_reg.chan1 == EDGE_RISE) | (edge_select_reg.chan1 == EDGE_BOTH)) & rise[1] |
     ((edge_select_reg.chan1 == EDGE_FALL) | (edge_select_reg.chan1 == EDGE_BOTH)) & fall[1]);

  assign clear_hit  = running & mode_pwm & (|cap_edge);
  assign wrap_evt   = running & tick & (count == CNT_MAX) & ~clear_hit;
  assign bitclr_req = wr_access & (paddr == OFF_BITCLR) & pstrb[0] & pwdata[BITCLR_BIT];
  assign optwr_clr  = wr_access & (paddr == OFF_OPTION) & pstrb[0] & ~pwdata[OPT_FLAG_BIT];
  // capture registers take no software writes
  assign ccr_wr[0]  = wr_access & (paddr == OFF_CCR0) & ~(mode_pwm | chan_function_select[0]);
  assign ccr_wr[1]  = wr_access & (paddr == OFF_CCR1) & ~(mode_pwm | chan_function_select[1]);

  always_comb begin
    next_timer_control_reg0       = timer_control_reg0;
    next_edge_select_reg          = edge_select_reg;
    next_chan_function_select     = chan_function_select;
    next_wrap_flag                = wrap_flag;
    next_chan_capture_compare_reg = chan_capture_compare_reg;
    next_count                    = count;
    next_timer_output_pin         = timer_output_pin;
    next_irq                      = 2'b00;
    next_wrap_irq                 = 1'b0;
    next_prdata                   = prdata;
    next_pslverr                  = pslverr;

    // software writes first, so hardware events below win
    if (wr_access && pstrb[0]) begin
      case (paddr)
        OFF_CTRL0:  next_timer_control_reg0 = pwdata[CTRL_W-1:0];
        OFF_EDGE:   next_edge_select_reg = pwdata[EDGE_W-1:0];
        OFF_OPTION: begin
          next_chan_function_select = {pwdata[OPT_CCS1_BIT], pwdata[OPT_CCS0_BIT]};
        end
        default: ;
      endcase
    end
    if (bitclr_req || optwr_clr) begin
      next_wrap_flag = 1'b0;
    end
    for (int a = 0; a < 2; a++) begin
      if (ccr_wr[a] && pstrb[0]) begin
        next_chan_capture_compare_reg[a][7:0] = pwdata[7:0];
      end
      if (ccr_wr[a] && pstrb[1]) begin
        next_chan_capture_compare_reg[a][15:8] = pwdata[15:8];
      end
    end

    if (starting) begin
      next_count = CNT_ZERO;
      if (mode_free) begin
        next_timer_output_pin = ~timer_output_pin;
      end
    end else if (running) begin
      for (int a = 0; a < 2; a++) begin
        if ((mode_pwm || chan_function_select[a]) && cap_edge[a]) begin
          next_chan_capture_compare_reg[a] = count;
          next_irq[a] = 1'b1;
        end else if (mode_free && !chan_function_select[a] && tick &&
                     count == chan_capture_compare_reg[a]) begin
          next_irq[a] = 1'b1;
          next_timer_output_pin[a] = ~timer_output_pin[a];
        end
      end
      if (clear_hit) begin
        next_count = CNT_ZERO;
      end else if (wrap_evt) begin
        next_count     = CNT_ZERO;
        next_wrap_irq  = 1'b1;
        next_wrap_flag = 1'b1;
      end else if (tick) begin
        next_count = count + CNT_ONE;
      end
    end

    if (setup) begin
      next_pslverr = 1'b0;
      case (paddr)
        OFF_CTRL0:  next_prdata = {27'h0, timer_control_reg0};
        OFF_OPTION: next_prdata = {26'h0, chan_function_select, 3'h0, wrap_flag};
        OFF_EDGE:   next_prdata = {28'h0, edge_select_reg};
        OFF_CCR0:   next_prdata = {16'h0, chan_capture_compare_reg[0]};
        OFF_CCR1:   next_prdata = {16'h0, chan_capture_compare_reg[1]};
        OFF_BITCLR: next_prdata = 32'h0;
        OFF_COUNT:  next_prdata = {16'h0, count};
        default: begin
          next_prdata  = 32'h0;
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_control_reg0          <= CTRL_RESET;
      edge_select_reg             <= EDGE_RESET;
      chan_function_select        <= 2'h0;
      wrap_flag                   <= 1'b0;
      chan_capture_compare_reg[0] <= CNT_ZERO;
      chan_capture_compare_reg[1] <= CNT_ZERO;
      count                       <= CNT_ZERO;
      run_q                       <= 1'b0;
      timer_output_pin            <= 2'h0;
      chan_match_capture_irq      <= 2'h0;
      counter_wrap_irq            <= 1'b0;
      prdata                      <= 32'h0;
      pslverr                     <= 1'b0;
      sync1                       <= 2'h0;
      sync2                       <= 2'h0;
      sync3                       <= 2'h0;
    end else begin
      timer_control_reg0       <= next_timer_control_reg0;
      edge_select_reg          <= next_edge_select_reg;
      chan_function_select     <= next_chan_function_select;
      wrap_flag                <= next_wrap_flag;
      chan_capture_compare_reg <= next_chan_capture_compare_reg;
      count                    <= next_count;
      run_q                    <= timer_control_reg0.run;
      timer_output_pin         <= next_timer_output_pin;
      chan_match_capture_irq   <= next_irq;
      counter_wrap_irq         <= next_wrap_irq;
      prdata                   <= next_prdata;
      pslverr                  <= next_pslverr;
      sync1                    <= {capture_input1_pin, capture_input0_pin};
      sync2                    <= sync1;
      sync3                    <= sync2;
    end
  end

  sequence s_wrap_now;
    wrap_evt;
  endsequence
  sequence s_wrap_seen;
    count == CNT_ZERO && counter_wrap_irq && wrap_flag;
  endsequence

  a_start_from_zero: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(timer_control_reg0.run) && !run_q |=> count == CNT_ZERO)
    else $error("counter did not start from zero");
  a_pwm_capture_clear: assert property (@(posedge clk_sys) disable iff (rst)
    running && mode_pwm && cap_edge[1] |=> count == CNT_ZERO &&
      chan_capture_compare_reg[1] == $past(count) && chan_match_capture_irq[1])
    else $error("pulse width capture wrong");
  a_wrap_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
    s_wrap_now |=> s_wrap_seen)
    else $error("wrap did not clear count and raise flag");
  a_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    wrap_flag && !bitclr_req && !optwr_clr |=> wrap_flag [*1])
    else $error("wrap flag lost without clear");
  a_flag_write_clear: assert property (@(posedge clk_sys) disable iff (rst)
    (bitclr_req || optwr_clr) && !wrap_evt |=> !wrap_flag)
    else $error("wrap flag not cleared");
  a_clear_wrap_wins: assert property (@(posedge clk_sys) disable iff (rst)
    bitclr_req && wrap_evt |=> wrap_flag ##1 1'b1)
    else $error("clear beat a coinciding wrap");
  a_ext_ch0_blind: assert property (@(posedge clk_sys) disable iff (rst)
    timer_control_reg0.ext_clk && !ccr_wr[0] |=> $stable(chan_capture_compare_reg[0]))
    else $error("channel 0 moved under external clock");
  a_compare_toggle: assert property (@(posedge clk_sys) disable iff (rst)
    running && mode_free && !chan_function_select[1] && tick && !cap_edge[1] &&
      count == chan_capture_compare_reg[1]
      |=> chan_match_capture_irq[1] && timer_output_pin[1] != $past(timer_output_pin[1]))
    else $error("compare match missed");
  a_capture_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (mode_pwm || chan_function_select[1]) && !cap_edge[1] && !wr_access
      |=> $stable(chan_capture_compare_reg[1]))
    else $error("capture register changed without edge");
endmodule

`default_nettype wire

// >>> tb/pulse_source.sv
// model of the external pulse sources feeding the two capture pins
`timescale 1ns/1ns
`default_nettype none
module pulse_source (
  input  wire logic clk_sys,
  output logic      pin0,
  output logic      pin1
);
  initial begin
    pin0 = 1'b0;
    pin1 = 1'b0;
  end
  // one-cycle high pulse on a single pin; the other pin stays idle low
  task automatic pulse(input int ch);
    @(posedge clk_sys);
    if (ch == 0) begin
      pin0 <= 1'b1;
    end else begin
      pin1 <= 1'b1;
    end
    @(posedge clk_sys);
    pin0 <= 1'b0;
    pin1 <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench of the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import timer_cap_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst     = 1'b1;
  apb_ctl_t   apb_ctl = '0;
  addr_t      paddr   = '0;
  data_t      pwdata  = '0;
  logic [3:0] pstrb   = 4'hF;
  logic       pready, pslverr, pin0, pin1, wrap_irq, err;
  data_t      prdata, q, a, c0, d, e;
  logic [1:0] out_pin, ch_irq;
  logic [2:0] ev;
  int         n_fail = 0, compares = 0, cyc = 0, tev, ta, tb, tk[4];
  data_t      cap[4];
  assign ev = {wrap_irq, ch_irq};

  timer_capture_pulse_width timer_capture_pulse_width_i (
    .clk_sys(clk_sys), .rst(rst), .apb_ctl(apb_ctl), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .capture_input0_pin(pin0), .capture_input1_pin(pin1), .timer_output_pin(out_pin),
    .chan_match_capture_irq(ch_irq), .counter_wrap_irq(wrap_irq));
  pulse_source pulse_source_i (.clk_sys(clk_sys), .pin0(pin0), .pin1(pin1));

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input data_t exp, input data_t got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input addr_t ad, input data_t dt);
    @(posedge clk_sys);
    apb_ctl <= '{psel: 1'b1, penable: 1'b0, pwrite: wr};
    paddr <= ad;
    pwdata <= dt;
    @(posedge clk_sys);
    apb_ctl.penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    q = prdata;
    err = pslverr;
    apb_ctl <= '0;
  endtask
  task automatic wait_ev(input int i);
    @(posedge clk_sys);
    while (ev[i] !== 1'b1) @(posedge clk_sys);
    tev = cyc;
  endtask

  initial begin
    void'($urandom(32'hBD8C));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    // register reset values and an unmapped address
    apb(0, OFF_CTRL0, '0);
    chk("ctrl0", 32'h0, q);
    apb(0, OFF_OPTION, '0);
    chk("option", 32'h0, q);
    apb(0, OFF_EDGE, '0);
    chk("edge", 32'h0, q);
    apb(0, 8'h1C, '0);
    chk("unmapped_err", 32'h1, data_t'(err));
    $display("test registers done");
    // free-running compare on both channels, rewrite while counting
    c0 = 32'h80 + ($urandom % 128);
    d = 32 + ($urandom % 200);
    e = 32 + ($urandom % 200);
    apb(1, OFF_CCR0, c0);
    apb(1, OFF_CCR1, c0 + d);
    apb(1, OFF_CTRL0, 32'h0D);
    apb(0, OFF_COUNT, '0);
    chk("pins_at_start", 32'h3, data_t'(out_pin));
    wait_ev(0);
    ta = tev;
    wait_ev(1);
    tb = tev;
    chk("match_spacing", d, data_t'(tb - ta));
    apb(1, OFF_CCR0, c0 + d + e);
    wait_ev(0);
    chk("rewrite_spacing", e, data_t'(tev - tb));
    chk("pins_after_match", 32'h1, data_t'(out_pin));
    $display("test compare done");
    // wrap, sticky flag; a bit-clear aimed at the wrap edge must lose
    apb(0, OFF_COUNT, '0);
    repeat (32'h0000FFFF - q - 4) @(posedge clk_sys);
    apb(1, OFF_BITCLR, 32'h1);
    ta = cyc;
    wait_ev(2);
    chk("wrap_at_clear", 32'h1, data_t'(tev - ta));
    apb(0, OFF_COUNT, '0);
    chk("count_after_wrap", 32'h1, data_t'(q < 32));
    apb(0, OFF_OPTION, '0);
    chk("flag_set", 32'h1, data_t'(q[OPT_FLAG_BIT]));
    apb(1, OFF_BITCLR, 32'h1);
    apb(0, OFF_OPTION, '0);
    chk("flag_cleared", 32'h0, data_t'(q[OPT_FLAG_BIT]));
    $display("test wrap done");
    // free-running capture on both channels
    apb(1, OFF_OPTION, 32'h30);
    apb(1, OFF_EDGE, 32'h5);
    ta = cyc;
    pulse_source_i.pulse(0);
    wait_ev(0);
    apb(0, OFF_CCR0, '0);
    a = q;
    pulse_source_i.pulse(1);
    wait_ev(1);
    repeat (20 + $urandom % 300) @(posedge clk_sys);
    tb = cyc;
    pulse_source_i.pulse(0);
    wait_ev(0);
    apb(0, OFF_CCR0, '0);
    chk("capture_diff", data_t'(16'(tb - ta)), data_t'(16'(q - a)));
    a = q;
    apb(1, OFF_CCR0, data_t'($urandom % 65536));
    apb(0, OFF_CCR0, '0);
    chk("capture_held", a, q);
    $display("test capture done");
    // pulse width measurement on input 1
    apb(1, OFF_CTRL0, 32'h0);
    apb(1, OFF_EDGE, 32'h4);
    apb(1, OFF_CTRL0, 32'h0E);
    apb(0, OFF_COUNT, '0);
    chk("count_from_zero", 32'h1, data_t'(q < 16));
    for (int k = 0; k < 4; k++) begin
      repeat (50 + $urandom % 400) @(posedge clk_sys);
      tk[k] = cyc;
      pulse_source_i.pulse(1);
      wait_ev(1);
      apb(0, OFF_CCR1, '0);
      cap[k] = q;
      if (k >= 2) begin
        chk("width_step", data_t'(tk[k] - 2 * tk[k-1] + tk[k-2]), cap[k] - cap[k-1]);
      end
    end
    $display("test pulse width done");
    // external count clock on input 0, width measured on input 1
    apb(1, OFF_CTRL0, 32'h0);
    apb(1, OFF_CTRL0, 32'h1E);
    c0 = 3 + $urandom % 10;
    repeat (c0) pulse_source_i.pulse(0);
    pulse_source_i.pulse(1);
    wait_ev(1);
    apb(0, OFF_CCR1, '0);
    chk("ext_clock_width", c0, q);
    $display("test external clock done");
    complete_run();
  end
endmodule
`default_nettype wire
